// file: design/sbrc_top.sv
// servo brake release control with apb register access
//
// Contract
// R01 - output low means brake engaged, shaft locked
// R02 - output high means brake released, shaft free
// R03 - separate programmable on and off delays
// R04 - servo off: engage after off delay elapses
// R05 - servo off: engage early below zero speed
// R06 - engagement only after servo is disabled; in external mode the command bit engages the brake while the servo is on
// R07 - external controller brakes only during deceleration; the block passes the release command bit at any speed
// R08 - delays in milliseconds, reset to zero
// R09 - zero speed threshold in rpm, default ten
// R10 - servo on: release after on delay
`timescale 1ns/100ps
module sbrc_top #(
	parameter int ms_count = sbrc_pkg::ms_cycles
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        servo_enable_input,
	input  wire logic [15:0] motor_speed,
	output logic             brake_release_output
);
	// ==========================================================
	// register map, all fields right aligned, upper bits read zero
	//   0x000 on delay, whole milliseconds, reset zero
	//   0x004 off delay, whole milliseconds, reset zero
	//   0x008 zero speed threshold, rpm, reset ten
	//   0x00c control: bit 0 external mode, bit 1 release command
	//   0x010 status, read only
	//     bit 0     brake release output as driven
	//     bit 1     synchronised servo enable
	//     bits 3:2  sequencer state
	//   any other address answers with a slave error
	//   a write to status or to an unmapped address is dropped
	//
	// bus timing
	//   one wait state on every access
	//   setup edge, then the first access edge raises ready
	//   read data and error stand for the ready cycle only
	//   a write lands at the edge that samples ready high
	//   read data is zero outside the ready cycle
	//   back to back transfers need no idle cycle
	//
	// brake sequencing
	//   engaged: output low, shaft held by the brake
	//   on wait: servo on, counting the on delay
	//   released: output high, shaft free to turn
	//   off wait: servo off, counting the off delay
	//   engaged to released at once when the on delay is zero
	//   released to engaged at once when the off delay is zero
	//   released to engaged at once below the zero speed threshold
	//   off wait ends early when speed drops below the threshold
	//   off wait ends when the off delay has run out
	//   servo back on during off wait returns to released
	//   servo off during on wait returns to engaged
	//
	// delay counting
	//   the tick counter restarts on entry to either wait state
	//   one tick every ms_count clocks
	//   the millisecond count compares with >=, so a delay
	//   shortened by a register write mid wait ends at the next tick
	//   a delay written during a wait applies to that wait
	//
	// latency from the pins
	//   two clocks through the synchronisers
	//   one clock through the sequencer register
	//   so an edge on the enable pin shows three clocks later
	//   at the earliest, plus any programmed delay
	//
	// speed input
	//   the speed word is synchronised bit by bit
	//   it must change slowly against the clock, so that a
	//   word torn across a change is off by little
	//   a torn word can at worst move an early engage by a
	//   clock, never engage while the servo is on
	//
	// external mode
	//   the output follows the release command bit with one
	//   clock of latency, whatever the servo enable does
	//   the state field then shows released while enabled
	//   and engaged while disabled, for software only
	//   the delay counter is held at zero in this mode
	//   the far controller must only brake while the motor
	//   decelerates, or the drive may see an overload
	//   leaving external mode resumes from the shown state
	//
	// hazards
	//   a zero threshold disables the early engage path
	//   a threshold above top speed engages at once on servo off
	//   the output is low through reset, so the brake holds
	//   while the block is held in reset
	//
	// ==========================================================
	// input synchronisers
	logic        en_meta;
	logic        en_sync;
	logic [15:0] spd_meta;
	logic [15:0] spd_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_meta  <= 1'b0;
			en_sync  <= 1'b0;
			spd_meta <= 16'h0000;
			spd_sync <= 16'h0000;
		end else begin
			en_meta  <= servo_enable_input;
			en_sync  <= en_meta;
			spd_meta <= motor_speed;
			spd_sync <= spd_meta;
		end
	end

	// ==========================================================
	// apb register file
	logic [15:0] brake_on_delay;
	logic [15:0] brake_off_delay;
	logic [15:0] zero_speed_threshold;
	logic [1:0]  control;
	logic [15:0] next_on_delay;
	logic [15:0] next_off_delay;
	logic [15:0] next_zero_speed;
	logic [1:0]  next_control;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        access;
	logic        hit;
	logic        commit;
	sbrc_pkg::sbrc_state_t state;
	sbrc_pkg::sbrc_state_t next_state;

	assign access = psel & penable & ~pready;
	// a write completes at the edge that samples ready high
	assign commit = psel & penable & pready & pwrite;

	// decode, write and read mux; one wait state per access
	always_comb begin
		next_on_delay   = brake_on_delay;
		next_off_delay  = brake_off_delay;
		next_zero_speed = zero_speed_threshold;
		next_control    = control;
		next_prdata     = prdata;
		next_pready     = access;
		next_pslverr    = 1'b0;
		hit             = 1'b1;
		unique case (paddr)
			sbrc_pkg::off_on_delay:   next_prdata = {16'h0000, brake_on_delay};
			sbrc_pkg::off_off_delay:  next_prdata = {16'h0000, brake_off_delay};
			sbrc_pkg::off_zero_speed: next_prdata = {16'h0000, zero_speed_threshold};
			sbrc_pkg::off_control:    next_prdata = {30'h00000000, control};
			sbrc_pkg::off_status:     next_prdata = {28'h0000000, state,
				en_sync, brake_release_output};
			default: begin
				next_prdata = 32'h00000000;
				hit         = 1'b0;
			end
		endcase
		if (access) begin
			next_pslverr = ~hit;
			if (pwrite) begin
				next_prdata = 32'h00000000;
			end
		end else begin
			next_prdata = 32'h00000000;
		end
		if (commit) begin
			unique case (paddr)
				sbrc_pkg::off_on_delay:   next_on_delay = pwdata[15:0]; // see R03
				sbrc_pkg::off_off_delay:  next_off_delay = pwdata[15:0]; // see R03
				sbrc_pkg::off_zero_speed: next_zero_speed = pwdata[15:0]; // see R09
				sbrc_pkg::off_control:    next_control = pwdata[1:0];
				default: ;
			endcase
		end
	end

	// register update; delays reset to zero, threshold to ten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brake_on_delay       <= sbrc_pkg::rst_on_delay; // see R08
			brake_off_delay      <= sbrc_pkg::rst_off_delay; // see R08
			zero_speed_threshold <= sbrc_pkg::rst_zero_speed; // see R09
			control              <= 2'h0;
			prdata               <= 32'h00000000;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
		end else begin
			brake_on_delay       <= next_on_delay;
			brake_off_delay      <= next_off_delay;
			zero_speed_threshold <= next_zero_speed;
			control              <= next_control;
			prdata               <= next_prdata;
			pready               <= next_pready;
			pslverr              <= next_pslverr;
		end
	end

	// ==========================================================
	// millisecond tick and delay counting
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic        tick;
	logic [15:0] ms_cnt;
	logic [15:0] next_ms_cnt;
	logic        next_release;
	logic        below_zero;
	logic        ext_mode;

	assign tick       = (tick_cnt == 32'(ms_count - 1));
	assign below_zero = (spd_sync < zero_speed_threshold);
	assign ext_mode   = control[sbrc_pkg::ctl_ext_mode_bit];

	// brake sequencer: delays count whole milliseconds
	always_comb begin
		next_state    = state;
		next_ms_cnt   = ms_cnt;
		next_release  = brake_release_output;
		next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
		if (ext_mode) begin
			// external controller owns the brake; it must keep to its
			// deceleration window, the block only passes its command
			next_state   = en_sync ? sbrc_pkg::sbrc_released
				: sbrc_pkg::sbrc_engaged;
			next_release = control[sbrc_pkg::ctl_ext_brake_bit]; // see R07
			next_ms_cnt  = 16'h0000;
		end else begin
			unique case (state)
				sbrc_pkg::sbrc_engaged: begin
					next_release = 1'b0; // see R01
					if (en_sync) begin
						next_state    = sbrc_pkg::sbrc_on_wait;
						next_ms_cnt   = 16'h0000;
						next_tick_cnt = 32'h00000000;
						if (brake_on_delay == 16'h0000) begin
							next_state   = sbrc_pkg::sbrc_released; // see R10
							next_release = 1'b1;
						end
					end
				end
				sbrc_pkg::sbrc_on_wait: begin
					if (!en_sync) begin
						next_state   = sbrc_pkg::sbrc_engaged;
						next_release = 1'b0;
					end else if (tick) begin
						next_ms_cnt = ms_cnt + 16'h0001;
						if (next_ms_cnt >= brake_on_delay) begin
							next_state   = sbrc_pkg::sbrc_released; // see R10
							next_release = 1'b1;
						end
					end
				end
				sbrc_pkg::sbrc_released: begin
					next_release = 1'b1; // see R02
					// engagement starts only from servo off
					if (!en_sync) begin // see R06
						next_state    = sbrc_pkg::sbrc_off_wait;
						next_ms_cnt   = 16'h0000;
						next_tick_cnt = 32'h00000000;
						if (brake_off_delay == 16'h0000 || below_zero) begin
							next_state   = sbrc_pkg::sbrc_engaged; // see R05
							next_release = 1'b0;
						end
					end
				end
				sbrc_pkg::sbrc_off_wait: begin
					if (en_sync) begin
						next_state   = sbrc_pkg::sbrc_released;
						next_release = 1'b1;
					end else if (below_zero) begin
						next_state   = sbrc_pkg::sbrc_engaged; // see R05
						next_release = 1'b0;
					end else if (tick) begin
						next_ms_cnt = ms_cnt + 16'h0001;
						if (next_ms_cnt >= brake_off_delay) begin
							next_state   = sbrc_pkg::sbrc_engaged; // see R04
							next_release = 1'b0;
						end
					end
				end
			endcase
		end
	end

	// sequencer registers; brake engaged from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                <= sbrc_pkg::sbrc_engaged;
			ms_cnt               <= 16'h0000;
			tick_cnt             <= 32'h00000000;
			brake_release_output <= 1'b0;
		end else begin
			state                <= next_state;
			ms_cnt               <= next_ms_cnt;
			tick_cnt             <= next_tick_cnt;
			brake_release_output <= next_release;
		end
	end
endmodule : sbrc_top

// file: design/sbrc_pkg.sv
// package of constants for the servo brake release control block
package sbrc_pkg;
	// register byte offsets
	localparam logic [11:0] off_on_delay   = 12'h000;
	localparam logic [11:0] off_off_delay  = 12'h004;
	localparam logic [11:0] off_zero_speed = 12'h008;
	localparam logic [11:0] off_control    = 12'h00c;
	localparam logic [11:0] off_status     = 12'h010;
	// field widths
	localparam int delay_w = 16;
	localparam int speed_w = 16;
	// reset values
	localparam logic [15:0] rst_on_delay   = 16'h0000;
	localparam logic [15:0] rst_off_delay  = 16'h0000;
	localparam logic [15:0] rst_zero_speed = 16'h000a;
	// control and status bit positions
	localparam int ctl_ext_mode_bit = 0;
	localparam int ctl_ext_brake_bit = 1;
	localparam int sts_release_bit = 0;
	localparam int sts_enable_bit = 1;
	localparam int sts_state_lsb = 2;
	// timing: one millisecond at the 25 MHz clock
	localparam int clk_khz = 25000;
	localparam int ms_time = 1;
	localparam int ms_cycles = clk_khz * ms_time;
	// brake sequencing states
	typedef enum logic [1:0] {
		sbrc_engaged  = 2'b00,
		sbrc_on_wait  = 2'b01,
		sbrc_released = 2'b10,
		sbrc_off_wait = 2'b11
	} sbrc_state_t;
endpackage : sbrc_pkg

// file: verif/sbrc_checker.sv
// port checker for the brake release control block
`timescale 1ns/100ps
module sbrc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        servo_enable_input,
	input wire logic [15:0] motor_speed,
	input wire logic        brake_release_output
);
	// ==========
	// bus and brake properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("lone error");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
		else $error("stray data");
	AST_OFF_FIRST: assert property ($fell(brake_release_output) |->
		!$past(servo_enable_input, 2)) else $error("early engage");
	AST_ON_FIRST: assert property ($rose(brake_release_output) |->
		$past(servo_enable_input, 2)) else $error("early release");
	AST_HOLD_ON: assert property (servo_enable_input [*4] |->
		!$fell(brake_release_output)) else $error("engaged while on");
	AST_LOCK_OFF: assert property ((!servo_enable_input &&
		motor_speed == 16'h0000) [*4] |=> !brake_release_output)
		else $error("not locked");
	// main scenarios
	cover property ($rose(brake_release_output));
	cover property ($fell(brake_release_output));
	cover property (pslverr);
endmodule : sbrc_checker

// file: verif/sbrc_motor_model.sv
// motor and brake relay model making the measured speed
`timescale 1ns/100ps
module sbrc_motor_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        brake_release_output,
	input  wire logic        load,
	input  wire logic        decel,
	output logic      [15:0] motor_speed
);
	logic [15:0] next_speed;
	// ==========
	// load spins up, decel slows, a held brake locks the shaft
	always_comb begin
		next_speed = motor_speed;
		if (load) begin
			next_speed = 16'h012c;
		end else if (!brake_release_output) begin
			next_speed = 16'h0000;
		end else if (decel && motor_speed > 16'h0009) begin
			next_speed = motor_speed - 16'h000a;
		end
	end
	// speed register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_speed <= 16'h0000;
		end else begin
			motor_speed <= next_speed;
		end
	end
endmodule : sbrc_motor_model

// file: verif/tb_sbrc_top.sv
// testbench for the servo brake release control block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module tb_sbrc_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, en = 1'b0, ld = 1'b0, dc = 1'b0;
	logic        pready, pslverr, er, brk;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [15:0] spd;
	int          n_errors = 0, tests_run = 0, n;
	// ==========
	// design and partner
	sbrc_top #(.ms_count(4)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .servo_enable_input(en), .motor_speed(spd),
		.brake_release_output(brk));
	sbrc_motor_model u_motor (.pclk(pclk), .presetn(presetn),
		.brake_release_output(brk), .load(ld), .decel(dc),
		.motor_speed(spd));
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// count edges until the brake output shows level v
	task wait_out(input logic v);
		n = 0;
		while (brk !== v && n < 1000) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_out
	// reset values and an unmapped access
	task t_reset;
		apb(1'b0, sbrc_pkg::off_on_delay, 32'h00000000);
		`CHK(rd, 32'h00000000)
		apb(1'b0, sbrc_pkg::off_off_delay, 32'h00000000);
		`CHK(rd, 32'h00000000)
		apb(1'b0, sbrc_pkg::off_zero_speed, 32'h00000000);
		`CHK(rd, 32'h0000000a)
		apb(1'b1, 12'h020, 32'h00000005);
		`CHK(er, 1'b1)
	endtask : t_reset
	// zero on delay releases at once, then timed off delay at speed
	task t_zero_and_off;
		@(posedge pclk);
		en <= 1'b1;
		wait_out(1'b1);
		`CHK(n <= 5, 1'b1)
		apb(1'b1, sbrc_pkg::off_off_delay, 32'h00000002);
		ld <= 1'b1;
		@(posedge pclk);
		ld <= 1'b0;
		en <= 1'b0;
		wait_out(1'b0);
		`CHK(n >= 10 && n <= 13, 1'b1)
	endtask : t_zero_and_off
	// three millisecond on delay
	task t_on_delay;
		apb(1'b1, sbrc_pkg::off_on_delay, 32'h00000003);
		apb(1'b0, sbrc_pkg::off_on_delay, 32'h00000000);
		`CHK(rd, 32'h00000003)
		en <= 1'b1;
		wait_out(1'b1);
		`CHK(n >= 14 && n <= 17, 1'b1)
	endtask : t_on_delay
	// long off delay cut short once speed drops below threshold
	task t_off_speed;
		apb(1'b1, sbrc_pkg::off_off_delay, 32'h00000064);
		apb(1'b1, sbrc_pkg::off_zero_speed, 32'h000000c8);
		ld <= 1'b1;
		@(posedge pclk);
		ld <= 1'b0;
		en <= 1'b0;
		repeat (30) @(posedge pclk);
		`CHK(brk, 1'b1)
		dc <= 1'b1;
		wait_out(1'b0);
		`CHK(n >= 13 && n <= 17, 1'b1)
	endtask : t_off_speed
	// external mode: output follows the release command bit
	task t_ext_mode;
		dc <= 1'b0;
		ld <= 1'b1;
		en <= 1'b1;
		wait_out(1'b1);
		`CHK(n >= 14 && n <= 17, 1'b1)
		ld <= 1'b0;
		apb(1'b1, sbrc_pkg::off_control, 32'h00000003);
		apb(1'b0, sbrc_pkg::off_status, 32'h00000000);
		`CHK(rd, 32'h0000000b)
		en <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK(brk, 1'b1)
		apb(1'b1, sbrc_pkg::off_control, 32'h00000001);
		wait_out(1'b0);
		`CHK(n <= 3, 1'b1)
		apb(1'b1, sbrc_pkg::off_control, 32'h00000000);
	endtask : t_ext_mode
	// counts and verdict
	task complete_run;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// clock, main sequence and watchdog
	initial begin
		forever #20 pclk = ~pclk;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_zero_and_off;
		t_on_delay;
		t_off_speed;
		t_ext_mode;
		complete_run;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		complete_run;
	end
endmodule : tb_sbrc_top
bind sbrc_top sbrc_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .servo_enable_input(servo_enable_input),
	.motor_speed(motor_speed), .brake_release_output(brake_release_output));
